/* File: logic/basmu_unit.sv */
`timescale 1ns/100ps
`default_nettype none

module basmu_unit #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_valid,
    input wire logic rung_enable,
    input wire logic [2:0] opcode,
    input wire logic use_immediate,
    input wire logic [31:0] immediate,
    input wire logic [15:0] mem_word_lo,
    input wire logic [15:0] mem_word_hi,
    output logic [31:0] accumulator,
    output logic step_done,
    output logic zero_flag,
    output logic negative_flag,
    output logic carry16_flag,
    output logic carry32_flag,
    output logic borrow16_flag,
    output logic borrow32_flag,
    output logic sign_error_flag,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        logic [31:0] acc;
        logic [basmu_pkg::FLAG_COUNT-1:0] flags;
        logic hold;
        logic [COUNT_WIDTH-1:0] count;
        logic done;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } basmu_state_t;

    basmu_state_t state;
    basmu_state_t next_state;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] basmu_merge(input logic [31:0] old_value,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] merged;
        merged = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return merged;
    endfunction : basmu_merge

    function automatic logic basmu_mapped(input logic [7:0] addr);
        logic hit;
        case (addr)
            basmu_pkg::ACC_OFFSET,
            basmu_pkg::FLAGS_OFFSET,
            basmu_pkg::CTRL_OFFSET,
            basmu_pkg::COUNT_OFFSET: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : basmu_mapped

    // Unmapped words answer with an error, reads and writes alike
    function automatic logic [1:0] basmu_resp(input logic [7:0] addr);
        return basmu_mapped(addr) ? basmu_pkg::RESP_OKAY : basmu_pkg::RESP_SLVERR;
    endfunction : basmu_resp

    function automatic logic [31:0] basmu_read_word(input logic [7:0] addr,
                                                    input basmu_state_t st);
        logic [31:0] word;
        case (addr)
            basmu_pkg::ACC_OFFSET: word = st.acc;
            basmu_pkg::FLAGS_OFFSET: word = {25'h0, st.flags};
            basmu_pkg::CTRL_OFFSET: word = {31'h0, st.hold};
            basmu_pkg::COUNT_OFFSET: word = 32'(st.count);
            default: word = 32'h0000_0000;
        endcase
        return word;
    endfunction : basmu_read_word

    // ----------------------------------------------------------------
    // Arithmetic helpers
    // ----------------------------------------------------------------
    // Bit 16 of the sum is the carry out
    function automatic logic [16:0] basmu_add17(input logic [15:0] a,
                                                input logic [15:0] b);
        return {1'b0, a} + {1'b0, b};
    endfunction : basmu_add17

    // Bit 16 of the difference is the borrow out
    function automatic logic [16:0] basmu_sub17(input logic [15:0] a,
                                                input logic [15:0] b);
        return {1'b0, a} - {1'b0, b};
    endfunction : basmu_sub17

    // Like signs in and the other sign out is a signed overflow
    function automatic logic basmu_overflow(input logic a_msb,
                                            input logic b_msb,
                                            input logic sum_msb);
        return (a_msb == b_msb) && (sum_msb != a_msb);
    endfunction : basmu_overflow

    // ----------------------------------------------------------------
    // Reset value
    // ----------------------------------------------------------------
    function automatic basmu_state_t basmu_reset_state();
        basmu_state_t st;
        st = '0;
        st.acc = basmu_pkg::ACC_RESET;
        st.flags = basmu_pkg::FLAGS_RESET;
        st.hold = basmu_pkg::HOLD_RESET;
        return st;
    endfunction : basmu_reset_state

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    logic [15:0] op16;
    logic [31:0] op32;
    logic [16:0] add16;
    logic [16:0] sub16;
    logic [32:0] add32;
    logic [32:0] sub32;
    logic [16:0] add32_low;
    logic [16:0] sub32_low;
    logic [31:0] product;
    logic step_taken;

    always_comb begin
        // Immediate sources clip to their documented width
        op16 = use_immediate ? immediate[15:0] : mem_word_lo;
        op32 = use_immediate ? immediate : {mem_word_hi, mem_word_lo};
        add16 = basmu_add17(state.acc[15:0], op16);
        sub16 = basmu_sub17(state.acc[15:0], op16);
        add32 = {1'b0, state.acc} + {1'b0, op32};
        sub32 = {1'b0, state.acc} - {1'b0, op32};
        add32_low = basmu_add17(state.acc[15:0], op32[15:0]);
        sub32_low = basmu_sub17(state.acc[15:0], op32[15:0]);
        // Only the low accumulator half enters the product
        product = 32'(state.acc[15:0]) * 32'(op16);
        // Steps without the rung condition leave acc and flags alone
        step_taken = step_valid && rung_enable && !state.hold;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] result;
        logic valid_op;
        logic aw_now;
        logic w_now;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        result = state.acc;
        valid_op = 1'b1;
        aw_now = 1'b0;
        w_now = 1'b0;
        waddr = state.aw_addr;
        wdata = state.w_data;
        wstrb = state.w_strb;
        next_state = state;
        next_state.done = 1'b0;

        // Write channel capture, address and data in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_ok = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
            waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_ok = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
            wdata = s_axi_wdata;
            wstrb = s_axi_wstrb;
        end
        aw_now = next_state.aw_ok;
        w_now = next_state.w_ok;

        if (aw_now && w_now && !state.bvalid) begin
            next_state.aw_ok = 1'b0;
            next_state.w_ok = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = basmu_resp(waddr);
            if (waddr == basmu_pkg::ACC_OFFSET) begin
                next_state.acc = basmu_merge(state.acc, wdata, wstrb);
            end
            if (waddr == basmu_pkg::CTRL_OFFSET && wstrb[0]) begin
                next_state.hold = wdata[basmu_pkg::HOLD_BIT];
            end
        end else if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Sequencer step; overrides a software load of the accumulator
        if (step_taken) begin
            case (opcode)
                basmu_pkg::OP_ADD_WORD: begin
                    result = {15'h0, add16};
                    next_state.flags[basmu_pkg::CARRY16_BIT] = add16[16];
                    next_state.flags[basmu_pkg::CARRY32_BIT] = 1'b0;
                    next_state.flags[basmu_pkg::SIGN_ERROR_BIT] =
                        basmu_overflow(state.acc[15], op16[15], add16[15]);
                end
                basmu_pkg::OP_ADD_DOUBLE_WORD: begin
                    result = add32[31:0];
                    next_state.flags[basmu_pkg::CARRY16_BIT] = add32_low[16];
                    next_state.flags[basmu_pkg::CARRY32_BIT] = add32[32];
                    next_state.flags[basmu_pkg::SIGN_ERROR_BIT] =
                        basmu_overflow(state.acc[31], op32[31], add32[31]);
                end
                basmu_pkg::OP_SUB_WORD: begin
                    result = {16'h0000, sub16[15:0]};
                    next_state.flags[basmu_pkg::BORROW16_BIT] = sub16[16];
                    next_state.flags[basmu_pkg::BORROW32_BIT] = 1'b0;
                end
                basmu_pkg::OP_SUB_DOUBLE_WORD: begin
                    result = sub32[31:0];
                    next_state.flags[basmu_pkg::BORROW16_BIT] = sub32_low[16];
                    next_state.flags[basmu_pkg::BORROW32_BIT] = sub32[32];
                end
                basmu_pkg::OP_MUL_WORD: begin
                    // Carry, borrow and sign error keep their values
                    result = product;
                end
                default: begin
                    valid_op = 1'b0;
                end
            endcase
            if (valid_op) begin
                // Result and flags land on the same edge
                next_state.acc = result;
                next_state.flags[basmu_pkg::ZERO_BIT] = result == 32'h0000_0000;
                next_state.flags[basmu_pkg::NEGATIVE_BIT] = result[31];
                // Taken-step counter wraps silently
                next_state.count = state.count + COUNT_WIDTH'(1);
                next_state.done = 1'b1;
            end
        end

        // Read channel; reads show the state before this edge
        if (s_axi_arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = basmu_resp(s_axi_araddr);
            next_state.rdata = basmu_read_word(s_axi_araddr, state);
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // One outstanding transfer each way keeps the slave simple
        next_state.awready = !next_state.aw_ok && !next_state.bvalid;
        next_state.wready = !next_state.w_ok && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Readies stay low through reset and rise one edge after
            state <= basmu_reset_state();
        end else begin
            // Untouched flags keep their last value
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign accumulator = state.acc;
    assign step_done = state.done;
    assign zero_flag = state.flags[basmu_pkg::ZERO_BIT];
    assign negative_flag = state.flags[basmu_pkg::NEGATIVE_BIT];
    assign carry16_flag = state.flags[basmu_pkg::CARRY16_BIT];
    assign carry32_flag = state.flags[basmu_pkg::CARRY32_BIT];
    assign borrow16_flag = state.flags[basmu_pkg::BORROW16_BIT];
    assign borrow32_flag = state.flags[basmu_pkg::BORROW32_BIT];
    assign sign_error_flag = state.flags[basmu_pkg::SIGN_ERROR_BIT];
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;

endmodule : basmu_unit

`default_nettype wire

/* File: logic/basmu_pkg.sv */
`default_nettype none

package basmu_pkg;
    // Register byte addresses
    localparam logic [7:0] ACC_OFFSET = 8'h00;
    localparam logic [7:0] FLAGS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_OFFSET = 8'h08;
    localparam logic [7:0] COUNT_OFFSET = 8'h0C;

    // Flag register bit positions
    localparam int ZERO_BIT = 0;
    localparam int NEGATIVE_BIT = 1;
    localparam int CARRY16_BIT = 2;
    localparam int CARRY32_BIT = 3;
    localparam int BORROW16_BIT = 4;
    localparam int BORROW32_BIT = 5;
    localparam int SIGN_ERROR_BIT = 6;
    localparam int FLAG_COUNT = 7;

    // Control register bit positions
    localparam int HOLD_BIT = 0;

    // Reset values
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [6:0] FLAGS_RESET = 7'h00;
    localparam logic HOLD_RESET = 1'b0;

    // Instruction codes
    localparam logic [2:0] OP_ADD_WORD = 3'h1;
    localparam logic [2:0] OP_ADD_DOUBLE_WORD = 3'h2;
    localparam logic [2:0] OP_SUB_WORD = 3'h3;
    localparam logic [2:0] OP_SUB_DOUBLE_WORD = 3'h4;
    localparam logic [2:0] OP_MUL_WORD = 3'h5;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : basmu_pkg

`default_nettype wire

/* File: bench/basmu_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module basmu_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_valid,
    input wire logic rung_enable,
    input wire logic [2:0] opcode,
    input wire logic use_immediate,
    input wire logic [31:0] immediate,
    input wire logic [15:0] mem_word_lo,
    input wire logic [15:0] mem_word_hi,
    input wire logic [31:0] accumulator,
    input wire logic step_done,
    input wire logic zero_flag,
    input wire logic negative_flag,
    input wire logic carry16_flag,
    input wire logic borrow32_flag,
    input wire logic sign_error_flag
);
    logic [31:0] b;
    logic go;
    // Hold is internal; the bench sets it only around a word subtract
    assign b = use_immediate ? immediate : {mem_word_hi, mem_word_lo};
    assign go = step_valid && rung_enable;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_done_cause: assert property (step_done |-> $past(go))
        else $error("done without step");
    chk_idle_flags: assert property (!go |=> $stable({zero_flag, negative_flag,
        carry16_flag, borrow32_flag, sign_error_flag}))
        else $error("flags moved while idle");
    chk_zero_flag: assert property (step_done |-> zero_flag == (accumulator == 32'h0))
        else $error("zero flag");
    chk_neg_flag: assert property (step_done |-> negative_flag == accumulator[31])
        else $error("negative flag");
    chk_add_word: assert property (go && opcode == basmu_pkg::OP_ADD_WORD |=>
        accumulator == $past(accumulator[15:0]) + $past(b[15:0]) && carry16_flag == accumulator[16])
        else $error("word add");
    chk_sub_double: assert property (go && opcode == basmu_pkg::OP_SUB_DOUBLE_WORD |=>
        accumulator == $past(accumulator) - $past(b) && borrow32_flag == ($past(accumulator) < $past(b)))
        else $error("double subtract");
    chk_mul_word: assert property (go && opcode == basmu_pkg::OP_MUL_WORD |=>
        accumulator == $past(accumulator[15:0]) * $past(b[15:0]))
        else $error("multiply");
    chk_add_sign: assert property (go && opcode == basmu_pkg::OP_ADD_DOUBLE_WORD |=>
        sign_error_flag == ($past(accumulator[31]) == $past(b[31]) &&
        accumulator[31] != $past(accumulator[31])))
        else $error("sign error");
endmodule : basmu_properties
bind basmu_unit basmu_properties i_basmu_properties (.aclk, .aresetn, .step_valid,
    .rung_enable, .opcode, .use_immediate, .immediate, .mem_word_lo, .mem_word_hi,
    .accumulator, .step_done, .zero_flag, .negative_flag, .carry16_flag, .borrow32_flag,
    .sign_error_flag);
`default_nettype wire

/* File: bench/basmu_seq_model.sv */
`timescale 1ns/100ps
`default_nettype none
module basmu_seq_model (
    input wire logic aclk,
    output logic step_valid,
    output logic rung_enable,
    output logic [2:0] opcode,
    output logic use_immediate,
    output logic [31:0] immediate,
    output logic [15:0] mem_word_lo,
    output logic [15:0] mem_word_hi
);
    initial begin
        {step_valid, rung_enable, opcode, use_immediate} = 6'h00;
        {immediate, mem_word_hi, mem_word_lo} = 64'h0;
    end
    // Unused operand source carries the inverse, never a stale copy
    task automatic issue(input logic [2:0] op, input logic [31:0] v, input logic imm,
            input logic rung);
        step_valid <= 1'b1;
        rung_enable <= rung;
        opcode <= op;
        use_immediate <= imm;
        immediate <= imm ? v : ~v;
        {mem_word_hi, mem_word_lo} <= imm ? ~v : v;
        @(posedge aclk);
    endtask : issue
    task automatic idle();
        step_valid <= 1'b0;
        rung_enable <= 1'b0;
        immediate <= ~immediate;
        {mem_word_hi, mem_word_lo} <= ~{mem_word_hi, mem_word_lo};
    endtask : idle
endmodule : basmu_seq_model
`default_nettype wire

/* File: bench/basmu_unit_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module basmu_unit_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic step_valid, rung_enable, use_immediate, step_done;
    logic [2:0] opcode;
    logic [31:0] immediate, accumulator, s_axi_rdata;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [15:0] mem_word_lo, mem_word_hi;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic zero_flag, negative_flag, carry16_flag, carry32_flag;
    logic borrow16_flag, borrow32_flag, sign_error_flag;
    logic [6:0] flags;
    logic [31:0] macc = 32'h0;
    logic [6:0] mflg = 7'h00;
    logic [38:0] step_q[$];
    logic [33:0] bus_q[$];
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int taken = 0;
    always #50 aclk = ~aclk;
    // Same bit order as the flag register
    assign flags = {sign_error_flag, borrow32_flag, borrow16_flag, carry32_flag, carry16_flag,
        negative_flag, zero_flag};
    basmu_seq_model i_basmu_seq_model (.aclk, .step_valid, .rung_enable, .opcode,
        .use_immediate, .immediate, .mem_word_lo, .mem_word_hi);
    basmu_unit i_basmu_unit (.aclk, .aresetn, .step_valid, .rung_enable, .opcode, .use_immediate,
        .immediate, .mem_word_lo, .mem_word_hi, .accumulator, .step_done, .zero_flag,
        .negative_flag, .carry16_flag, .carry32_flag, .borrow16_flag, .borrow32_flag,
        .sign_error_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task automatic check(input string what, input logic [38:0] seen, input logic [38:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    function automatic logic [38:0] model(input logic [2:0] op, input logic [31:0] a,
            input logic [31:0] b, input logic [6:0] f);
        logic [32:0] s;
        logic [16:0] w;
        w = {1'b0, a[15:0]} + {1'b0, b[15:0]};
        s = {1'b0, a} + {1'b0, b};
        case (op)
            3'h1: begin
                s = {16'h0, w};
                f[3:2] = {1'b0, w[16]};
                f[6] = a[15] == b[15] && w[15] != a[15];
            end
            3'h2: begin
                f[3:2] = {s[32], w[16]};
                f[6] = a[31] == b[31] && s[31] != a[31];
            end
            3'h3: begin
                w = {1'b0, a[15:0]} - {1'b0, b[15:0]};
                s = {17'h0, w[15:0]};
                f[5:4] = {1'b0, w[16]};
            end
            3'h4: begin
                s = {1'b0, a} - {1'b0, b};
                f[5:4] = {s[32], a[15:0] < b[15:0]};
            end
            default: s = 33'(a[15:0]) * 33'(b[15:0]);
        endcase
        f[1:0] = {s[31], s[31:0] == 32'h0};
        return {s[31:0], f};
    endfunction : model
    task automatic step(input logic [2:0] op, input logic [31:0] v, input logic imm,
            input logic rung);
        if (rung && op inside {[3'h1:3'h5]}) begin
            {macc, mflg} = model(op, macc, v, mflg);
            step_q.push_back({macc, mflg});
            taken++;
        end
        i_basmu_seq_model.issue(op, v, imm, rung);
    endtask : step
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : bus_read
    always @(posedge aclk) begin
        cycles++;
        if (step_done === 1'b1) begin
            check("acc and flags", {accumulator, flags}, step_q.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
            check("write resp", {5'h0, s_axi_bresp, 32'h0}, {5'h0, bus_q.pop_front()});
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
            check("read", {5'h0, s_axi_rresp, s_axi_rdata}, {5'h0, bus_q.pop_front()});
        end
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        int i;
        logic [31:0] pre[7] = '{32'hFFFF, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0, 32'h0, 32'hFFFF,
            32'h8000};
        logic [31:0] opd[7] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'hFFFF, 32'h8000};
        logic [2:0] ops[7] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
        void'($urandom(32131));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus_read(basmu_pkg::FLAGS_OFFSET, 32'h0, basmu_pkg::RESP_OKAY);
        bus_read(8'h10, 32'h0, basmu_pkg::RESP_SLVERR);
        bus_write(8'h14, 32'hA5A5_5A5A, basmu_pkg::RESP_SLVERR);
        // Carry, borrow and overflow corners, each flag read back over the bus
        for (i = 0; i < 7; i++) begin
            bus_write(basmu_pkg::ACC_OFFSET, pre[i], basmu_pkg::RESP_OKAY);
            macc = pre[i];
            step(ops[i], opd[i], i[0], 1'b1);
            i_basmu_seq_model.idle();
            bus_read(basmu_pkg::FLAGS_OFFSET, {25'h0, mflg}, basmu_pkg::RESP_OKAY);
        end
        // Hold set: a valid step is refused and nothing moves
        bus_write(basmu_pkg::CTRL_OFFSET, 32'h1, basmu_pkg::RESP_OKAY);
        i_basmu_seq_model.issue(basmu_pkg::OP_SUB_WORD, 32'h1, 1'b1, 1'b1);
        i_basmu_seq_model.idle();
        bus_read(basmu_pkg::CTRL_OFFSET, 32'h1, basmu_pkg::RESP_OKAY);
        bus_read(basmu_pkg::ACC_OFFSET, macc, basmu_pkg::RESP_OKAY);
        bus_read(basmu_pkg::FLAGS_OFFSET, {25'h0, mflg}, basmu_pkg::RESP_OKAY);
        bus_write(basmu_pkg::CTRL_OFFSET, 32'h0, basmu_pkg::RESP_OKAY);
        // Back to back, with bad codes and dropped rung mixed in
        for (i = 0; i < 80; i++) begin
            step(3'($urandom_range(7, 0)), $urandom, 1'($urandom), $urandom_range(3, 0) != 0);
        end
        i_basmu_seq_model.idle();
        bus_read(basmu_pkg::ACC_OFFSET, macc, basmu_pkg::RESP_OKAY);
        bus_read(basmu_pkg::COUNT_OFFSET, 32'(taken), basmu_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("pending steps", 39'(step_q.size()), 39'h0);
        end_of_test();
    end
endmodule : basmu_unit_tb
`default_nettype wire
